// ---- hdl/panel_mode_cmds.sv ----
// Operation
// R01: blank command is 28h on link, 2800h on serial, no parameters.
// R02: while blanked, incoming pixels are dropped and a black page is sent.
// R03: blank and unblank commands touch only the display on flag.
// R04: blank command while already blanked does nothing.
// R05: unblank command 29h or 2900h moves display to the on state.
// R06: commands are accepted in every mode, sleep included.
// R07: after any reset the display starts blanked.
// R08: tear disable command is 34h on link, 3400h on serial.
// R09: tear disable stops driving the active low tear sync output.
// R10: tear disable while already disabled does nothing.
// R11: tear state resets to 00h, output disabled, after any reset.
// R12: only tear enable 35h re-enables; its bit selects vblank or both.
// R13: two flags update only on matching codes and go to panel timing.
`timescale 1ns/100ps
`default_nettype none

package panel_mode_pkg;

  // command codes, link byte form and 16-bit serial word form
  localparam logic [7:0]  BLANK_CODE_DSI    = 8'h28;
  localparam logic [15:0] BLANK_CODE_SPI    = 16'h2800;
  localparam logic [7:0]  UNBLANK_CODE_DSI  = 8'h29;
  localparam logic [15:0] UNBLANK_CODE_SPI  = 16'h2900;
  localparam logic [7:0]  TEAR_OFF_CODE_DSI = 8'h34;
  localparam logic [15:0] TEAR_OFF_CODE_SPI = 16'h3400;
  localparam logic [7:0]  TEAR_ON_CODE_DSI  = 8'h35;
  localparam logic [15:0] TEAR_ON_CODE_SPI  = 16'h3500;

  // reset values
  localparam logic [7:0]  TEAR_STATE_RESET  = 8'h00;
  localparam logic        DISP_ON_RESET     = 1'b0;
  localparam logic        BLANK_RESET       = 1'b1;

  // field positions
  localparam int          TEAR_ENABLE_BIT   = 7;
  localparam int          TEAR_MODE_BIT     = 0;

  localparam int          PIX_W             = 24;
  localparam logic [23:0] BLANK_PIXEL       = 24'h00_0000;

  typedef struct packed {
    logic        valid;
    logic        spi;
    logic [15:0] code;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } param_t;

  typedef struct packed {
    logic             valid;
    logic [PIX_W-1:0] data;
  } pix_t;

  typedef enum logic [0:0] {
    ST_IDLE       = 1'b0,
    ST_WAIT_PARAM = 1'b1
  } parse_state_t;

endpackage : panel_mode_pkg

module panel_mode_cmds (
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  sw_reset_in,
  input  wire panel_mode_pkg::cmd_t   cmd_in,
  input  wire panel_mode_pkg::param_t param_in,
  input  wire logic                  sleep_in,
  input  wire logic                  vblank_in,
  input  wire logic                  hblank_in,
  input  wire panel_mode_pkg::pix_t   pix_in,
  output var  panel_mode_pkg::pix_t   pix_out,
  output var  logic                  disp_on_out,
  output var  logic                  blank_out,
  output var  logic                  tear_en_out,
  output var  logic                  tear_mode_out,
  output var  logic                  tear_n_out,
  output var  logic                  tear_oe_out
);

  // power-on, software and hardware reset all land on the same defaults
  logic rst;
  assign rst = sys_rst_in | sw_reset_in; // R07 R11

  // command decode
  function automatic logic code_hit(input panel_mode_pkg::cmd_t c,
                                    input logic [7:0]          dsi,
                                    input logic [15:0]         spi);
    logic hit;
    hit = 1'b0;
    if (c.valid) begin
      hit = c.spi ? (c.code == spi) : (c.code[7:0] == dsi);
    end
    return hit;
  endfunction : code_hit

  logic blank_hit;
  logic unblank_hit;
  logic tear_off_hit;
  logic tear_on_hit;

  // sleep_in is deliberately not a qualifier here
  always_comb begin
    blank_hit    = code_hit(cmd_in, panel_mode_pkg::BLANK_CODE_DSI,
                            panel_mode_pkg::BLANK_CODE_SPI); // R01 R06
    unblank_hit  = code_hit(cmd_in, panel_mode_pkg::UNBLANK_CODE_DSI,
                            panel_mode_pkg::UNBLANK_CODE_SPI); // R05 R06
    tear_off_hit = code_hit(cmd_in, panel_mode_pkg::TEAR_OFF_CODE_DSI,
                            panel_mode_pkg::TEAR_OFF_CODE_SPI); // R08
    tear_on_hit  = code_hit(cmd_in, panel_mode_pkg::TEAR_ON_CODE_DSI,
                            panel_mode_pkg::TEAR_ON_CODE_SPI); // R12
  end

  // parameter capture for the tear enable command
  panel_mode_pkg::parse_state_t state_r;
  panel_mode_pkg::parse_state_t state_nxt;
  logic                         tear_mode_r;
  logic                         tear_mode_nxt;
  logic                         tear_set;

  // a new command other than tear enable while waiting abandons the pending enable
  always_comb begin
    state_nxt     = state_r;
    tear_mode_nxt = tear_mode_r;
    tear_set      = 1'b0;
    unique case (state_r)
      panel_mode_pkg::ST_IDLE: begin
        if (tear_on_hit) begin
          state_nxt = panel_mode_pkg::ST_WAIT_PARAM;
        end
      end
      panel_mode_pkg::ST_WAIT_PARAM: begin
        if (cmd_in.valid) begin
          state_nxt = tear_on_hit ? panel_mode_pkg::ST_WAIT_PARAM
                                  : panel_mode_pkg::ST_IDLE;
        end else if (param_in.valid) begin
          state_nxt     = panel_mode_pkg::ST_IDLE;
          tear_set      = 1'b1; // R12
          tear_mode_nxt = param_in.data[panel_mode_pkg::TEAR_MODE_BIT];
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      state_r     <= panel_mode_pkg::ST_IDLE;
      tear_mode_r <= panel_mode_pkg::TEAR_STATE_RESET[
                       panel_mode_pkg::TEAR_MODE_BIT]; // R11
    end else begin
      state_r     <= state_nxt;
      tear_mode_r <= tear_mode_nxt;
    end
  end

  // the two mode flags
  logic disp_on;
  logic tear_en;

  // a clear on an already clear flag is a no-op by construction
  mode_flag #(
    .RESET_VAL (panel_mode_pkg::DISP_ON_RESET)
  ) u_disp_flag (
    .clk_in     (clk_in),
    .sys_rst_in (rst),
    .set_in     (unblank_hit), // R05 R13
    .clr_in     (blank_hit),   // R03 R04 R13
    .flag_out   (disp_on)
  );

  mode_flag #(
    .RESET_VAL (panel_mode_pkg::TEAR_STATE_RESET[
                  panel_mode_pkg::TEAR_ENABLE_BIT])
  ) u_tear_flag (
    .clk_in     (clk_in),
    .sys_rst_in (rst),
    .set_in     (tear_set),     // R12 R13
    .clr_in     (tear_off_hit), // R09 R10 R13
    .flag_out   (tear_en)
  );

  assign disp_on_out   = disp_on;
  assign tear_en_out   = tear_en;
  assign tear_mode_out = tear_mode_r;

  // pixel path and tear sync line
  logic                 blank_r;
  logic                 blank_nxt;
  logic                 vblank_d_r;
  panel_mode_pkg::pix_t pix_r;
  panel_mode_pkg::pix_t pix_nxt;
  logic                 tear_n_r;
  logic                 tear_n_nxt;
  logic                 tear_oe_r;
  logic                 tear_oe_nxt;

  // blanking follows the flag only at a frame start, so a page is never
  // cut in half; the cost is up to one frame of latency
  always_comb begin
    blank_nxt = blank_r;
    if (vblank_in && !vblank_d_r) begin
      blank_nxt = !disp_on; // R02
    end
    pix_nxt.valid = pix_in.valid;
    pix_nxt.data  = blank_r ? panel_mode_pkg::BLANK_PIXEL
                            : pix_in.data; // R02
    tear_oe_nxt   = tear_en; // R09
    tear_n_nxt    = !(tear_en &&
                      (vblank_in || (tear_mode_r && hblank_in))); // R12
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      blank_r    <= panel_mode_pkg::BLANK_RESET; // R07
      vblank_d_r <= 1'b0;
      pix_r      <= '0;
      tear_n_r   <= 1'b1;
      tear_oe_r  <= 1'b0; // R11
    end else begin
      blank_r    <= blank_nxt;
      vblank_d_r <= vblank_in;
      pix_r      <= pix_nxt;
      tear_n_r   <= tear_n_nxt;
      tear_oe_r  <= tear_oe_nxt;
    end
  end

  assign pix_out     = pix_r;
  assign blank_out   = blank_r;
  assign tear_n_out  = tear_n_r;
  assign tear_oe_out = tear_oe_r;

  // checks; a reset edge itself is kept out of every antecedent but that of a_reset_default
  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (rst);

  sequence s_tear_on_cmd;
    tear_on_hit && state_r == panel_mode_pkg::ST_IDLE;
  endsequence

  sequence s_tear_param;
    !cmd_in.valid && param_in.valid;
  endsequence

  a_blank_cmd_off: assert property ( // R01
    blank_hit && !unblank_hit |=> !disp_on_out
  ) else $error("blank command did not clear display on flag");

  a_unblank_cmd_on: assert property ( // R05
    unblank_hit |=> disp_on_out
  ) else $error("unblank command did not set display on flag");

  a_blank_keeps_tear: assert property ( // R03
    (blank_hit || unblank_hit) && state_r == panel_mode_pkg::ST_IDLE
    |=> $stable(tear_en_out) && $stable(tear_mode_out)
  ) else $error("display command disturbed tear state");

  a_blank_idem: assert property ( // R04
    blank_hit && !disp_on_out |=> !disp_on_out
  ) else $error("repeated blank command changed state");

  a_blank_pixels: assert property ( // R02
    !rst && blank_r && pix_in.valid
    |=> pix_out.valid && pix_out.data == panel_mode_pkg::BLANK_PIXEL
  ) else $error("pixel data leaked while blanked");

  a_blank_frame: assert property ( // R02
    !rst && vblank_in && !vblank_d_r
    |=> blank_out == !$past(disp_on_out)
  ) else $error("blanking not updated at frame start");

  a_sleep_accept: assert property ( // R06
    sleep_in && unblank_hit |=> disp_on_out
  ) else $error("command refused in sleep");

  a_tear_off_pin: assert property ( // R09
    tear_off_hit && state_r == panel_mode_pkg::ST_IDLE
    |=> ##1 !tear_oe_out && tear_n_out
  ) else $error("tear output still driven after disable");

  a_tear_off_idem: assert property ( // R10
    tear_off_hit && !tear_en_out |=> !tear_en_out && $stable(tear_mode_out)
  ) else $error("tear disable while off had an effect");

  a_tear_on_seq: assert property ( // R12
    s_tear_on_cmd ##1 s_tear_param
    |=> tear_en_out
        && tear_mode_out
           == $past(param_in.data[panel_mode_pkg::TEAR_MODE_BIT])
  ) else $error("tear enable with mode not applied");

  a_tear_vblank: assert property ( // R12
    !rst && tear_en_out && vblank_in |=> !tear_n_out && tear_oe_out
  ) else $error("tear sync not low in vertical blanking");

  a_tear_hblank: assert property ( // R12
    !rst && tear_en_out && tear_mode_out && hblank_in |=> !tear_n_out
  ) else $error("tear sync not low in horizontal blanking");

  a_tear_vb_only: assert property ( // R12
    !rst && tear_en_out && !tear_mode_out && !vblank_in |=> tear_n_out
  ) else $error("tear sync low outside vblank in mode 0");

  a_tear_pin_idle: assert property ( // R09 R11
    !tear_en_out |=> !tear_oe_out && tear_n_out
  ) else $error("tear line driven while disabled");

  a_disp_hold: assert property ( // R13
    !rst && !blank_hit && !unblank_hit |=> $stable(disp_on_out)
  ) else $error("display flag moved without its command");

  a_tear_en_hold: assert property ( // R13
    !rst && !tear_set && !tear_off_hit |=> $stable(tear_en_out)
  ) else $error("tear enable moved without its command");

  a_reset_default: assert property ( // R07 R11
    disable iff (1'b0)
    rst |=> !disp_on_out && !tear_en_out && !tear_oe_out && blank_out
  ) else $error("reset defaults wrong");

endmodule : panel_mode_cmds

`default_nettype wire

// ---- hdl/mode_flag.sv ----
`timescale 1ns/100ps
`default_nettype none

module mode_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output var  logic flag_out
);

  logic flag_r;
  logic flag_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (clr_in) begin
      flag_nxt = 1'b0;
    end
    if (set_in) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule : mode_flag

`default_nettype wire

// ---- dv/host_link.sv ----
`timescale 1ns/100ps
`default_nettype none

// host end of the command link: one code, then a parameter byte if asked
module host_link (
  input  wire logic                   clk_in,
  output var  panel_mode_pkg::cmd_t   cmd_out,
  output var  panel_mode_pkg::param_t param_out
);
  initial begin
    cmd_out   = '0;
    param_out = '0;
  end

  task automatic send(input logic spi, input logic [7:0] op,
                      input logic has_par, input logic [7:0] par);
    @(posedge clk_in);
    cmd_out <= {1'b1, spi, spi ? {op, 8'h00} : {8'h00, op}};
    @(posedge clk_in);
    cmd_out <= '0;
    // stray parameter after other codes only when a test asks for it
    if (has_par) begin
      param_out <= {1'b1, par};
      @(posedge clk_in);
      param_out <= '0;
    end
  endtask : send
endmodule : host_link

`default_nettype wire

// ---- dv/display_and_tear_line_cmds_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module display_and_tear_line_cmds_test;
  typedef struct packed {
    logic       spi;
    logic [7:0] op;
    logic       hp;
    logic [7:0] par;
    logic       disp;
    logic       ten;
    logic       tmode;
  } row_t;

  logic                   clk;
  logic                   rst;
  logic                   sw_rst;
  logic                   sleep;
  logic                   vb;
  logic                   hb;
  panel_mode_pkg::cmd_t   cmd;
  panel_mode_pkg::param_t prm;
  panel_mode_pkg::pix_t   pin;
  panel_mode_pkg::pix_t   pout;
  logic                   disp, blank, ten, tmode, tn, toe;
  int                     fails;
  int                     checked;
  row_t                   rows [12];

  initial clk = 1'b0;
  always #25 clk = ~clk;

  host_link link (.clk_in(clk), .cmd_out(cmd), .param_out(prm));

  panel_mode_cmds DUT (
    .clk_in(clk), .sys_rst_in(rst), .sw_reset_in(sw_rst), .cmd_in(cmd),
    .param_in(prm), .sleep_in(sleep), .vblank_in(vb), .hblank_in(hb),
    .pix_in(pin), .pix_out(pout), .disp_on_out(disp), .blank_out(blank),
    .tear_en_out(ten), .tear_mode_out(tmode), .tear_n_out(tn),
    .tear_oe_out(toe)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic vrise;
    @(posedge clk);
    vb <= 1'b1;
    repeat (2) @(posedge clk);
    vb <= 1'b0;
  endtask : vrise

  // panel switch waits for a frame boundary, so poll within a bound
  task automatic wait_blank(input logic exp);
    int n = 0;
    while (blank !== exp && n < 8) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    check(blank, exp, "blank switch");
  endtask : wait_blank

  initial begin
    rst = 1'b1; sw_rst = 1'b0; sleep = 1'b0; vb = 1'b0; hb = 1'b0;
    pin = '0; fails = 0; checked = 0;
    rows = '{'{1'b0, 8'h29, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
             '{1'b1, 8'h29, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
             '{1'b0, 8'h28, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
             '{1'b1, 8'h28, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
             '{1'b1, 8'h29, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
             '{1'b0, 8'h35, 1'b1, 8'h01, 1'b1, 1'b1, 1'b1},
             '{1'b0, 8'h34, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
             '{1'b1, 8'h34, 1'b0, 8'h00, 1'b1, 1'b0, 1'b1},
             '{1'b1, 8'h35, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0},
             '{1'b0, 8'h28, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
             '{1'b0, 8'h2a, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
             '{1'b1, 8'h34, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(disp, 1'b0, "disp after reset");
    check(blank, 1'b1, "blank after reset");
    check({ten, tmode, toe, tn}, 4'b0001, "tear after reset");
    foreach (rows[i]) begin
      @(posedge clk);
      sleep <= i[0];
      link.send(rows[i].spi, rows[i].op, rows[i].hp, rows[i].par);
      settle();
      check(disp, rows[i].disp, "disp flag");
      check({ten, tmode}, {rows[i].ten, rows[i].tmode}, "tear");
    end
    link.send(1'b0, 8'h35, 1'b1, 8'h00);
    vb <= 1'b1;
    settle();
    check({toe, tn}, 2'b10, "tear in vblank");
    @(posedge clk);
    vb <= 1'b0;
    hb <= 1'b1;
    settle();
    check(tn, 1'b1, "hblank in mode 0");
    @(posedge clk);
    vb <= 1'b1;
    link.send(1'b0, 8'h34, 1'b0, 8'h00);
    settle();
    check({toe, tn}, 2'b01, "tear pin off");
    @(posedge clk);
    vb <= 1'b0;
    hb <= 1'b0;
    pin <= {1'b1, 24'h12_3456};
    link.send(1'b0, 8'h29, 1'b0, 8'h00);
    vrise();
    wait_blank(1'b0);
    check(pout, {1'b1, 24'h12_3456}, "pixels pass");
    link.send(1'b1, 8'h28, 1'b0, 8'h00);
    vrise();
    wait_blank(1'b1);
    check(pout, {1'b1, 24'h00_0000}, "blank page");
    // a command between the enable code and its byte drops the enable
    link.send(1'b0, 8'h35, 1'b0, 8'h00);
    link.send(1'b0, 8'h29, 1'b1, 8'h01);
    settle();
    check({disp, ten}, 2'b10, "enable aborted");
    link.send(1'b1, 8'h35, 1'b1, 8'h01);
    hb <= 1'b1;
    settle();
    check({ten, tmode, tn}, 3'b110, "hblank in mode 1");
    // unblank first so the reset below has something to undo
    vrise();
    wait_blank(1'b0);
    @(posedge clk);
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    @(negedge clk);
    check({disp, blank}, 2'b01, "display after sw reset");
    check({ten, tmode, toe, tn}, 4'b0001, "tear after sw reset");
    tally_and_finish();
  end
endmodule : display_and_tear_line_cmds_test

`default_nettype wire
